// ---- afp_defines.svh ----
`ifndef AFP_DEFINES_SVH
`define AFP_DEFINES_SVH

// serial word and link timing
`define AFP_WORD_BITS     24
`define AFP_CNT_FULL      5'h18
`define AFP_CNT_LAST      5'h17
`define AFP_SCLK_HALF     8

// device control register layout
`define AFP_CTRL_RESET    24'h000000
`define AFP_MD_HI         23
`define AFP_MD_LO         21
`define AFP_IO_BIT        14
`define AFP_UNI_BIT       12
`define AFP_MD_NORMAL     3'h0
`define AFP_MD_SELF_CAL   3'h1
`define AFP_MD_SYS_CAL    3'h2
`define AFP_MD_COEF       3'h7

// synchroniser idle levels
`define AFP_DEV_PIN_IDLE  7'h2E
`define AFP_HST_PIN_IDLE  3'h6

// host wishbone register map
`define AFP_REG_CTRL      8'h00
`define AFP_REG_TXDATA    8'h04
`define AFP_REG_RXDATA    8'h08
`define AFP_REG_STATUS    8'h0C
`define AFP_REG_IRQ_STAT  8'h10
`define AFP_REG_IRQ_MASK  8'h14
`define AFP_CTRL_GO       0
`define AFP_CTRL_READ     1
`define AFP_CTRL_SEL      2
`define AFP_CTRL_EXT      3
`define AFP_IRQ_DONE      0
`define AFP_IRQ_RDY       1

`endif

// ---- afp_pkg.sv ----
package afp_pkg;
    typedef enum logic [1:0] {DEV_IDLE, DEV_WRITE, DEV_READ} afp_dev_state_t;
    typedef enum logic [2:0] {HST_IDLE, HST_WAIT_RDY, HST_SETUP, HST_SHIFT, HST_END} afp_hst_state_t;
endpackage : afp_pkg

// ---- afp_link_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface afp_link_if;
    logic dev_sclk_o;
    logic dev_sclk_oe;
    logic host_sclk_o;
    logic host_sclk_oe;
    logic dev_serial_data_io_o;
    logic dev_serial_data_io_oe;
    logic host_serial_data_io_o;
    logic host_serial_data_io_oe;
    logic write_frame_sync_n;
    logic read_frame_sync_n;
    logic result_ready_n;
    logic register_select;
    logic sclk;
    logic serial_data_io;

    // idle levels stand in for pull resistors on the board
    assign sclk           = dev_sclk_oe ? dev_sclk_o : (host_sclk_oe ? host_sclk_o : 1'b0);
    assign serial_data_io = dev_serial_data_io_oe ? dev_serial_data_io_o : (host_serial_data_io_oe ? host_serial_data_io_o : 1'b1);

    modport device (
        input  sclk, serial_data_io, write_frame_sync_n, read_frame_sync_n, register_select,
        output dev_sclk_o, dev_sclk_oe, dev_serial_data_io_o, dev_serial_data_io_oe, result_ready_n
    );
    modport host (
        input  sclk, serial_data_io, result_ready_n,
        output host_sclk_o, host_sclk_oe, host_serial_data_io_o, host_serial_data_io_oe,
        output write_frame_sync_n, read_frame_sync_n, register_select
    );
endinterface : afp_link_if
`default_nettype wire

// ---- afp_device.sv ----
// Function
// - write frame low starts word intake
// - self mode: clock runs after write frame
// - external mode: frame before first bit
// - read frame low requests device data
// - self mode read: drive clock and data
// - external mode read: drive data only
// - new result drives ready low
// - ready high after full word out
// - ready low marks calibration done
// - result read only while ready low
// - written bits sampled on rising clock
// - unipolar natural, bipolar offset binary
// - write control/coefficients, read also data
// - control bit switches compensation current
// - mode pin high selects self clocking
// - select low targets control register
// - load only full word, ignore extras
// - filter sync resets filter nodes
`timescale 1ns/10ps
`default_nettype none
`include "afp_defines.svh"
module afp_device
    import afp_pkg::*;
#(
    parameter int SCLK_HALF = `AFP_SCLK_HALF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    afp_link_if.device       link,
    input  wire logic        clock_mode_i,
    input  wire logic        filter_sync_n_i,
    input  wire logic [23:0] sample_i,
    input  wire logic        sample_valid_i,
    input  wire logic        cal_done_i,
    output logic      [23:0] control_o,
    output logic      [23:0] cal_coef_o,
    output logic             cal_start_o,
    output logic             current_on_o,
    output logic             filter_reset_o
);
    localparam int P_SCLK  = 0;
    localparam int P_SERIAL_DATA_IO = 1;
    localparam int P_TFS   = 2;
    localparam int P_RFS   = 3;
    localparam int P_SEL   = 4;
    localparam int P_FSYNC = 5;
    localparam int P_MODE  = 6;
    localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);

    function automatic logic [23:0] code_sample(input logic [23:0] s, input logic uni);
        if (uni) begin
            code_sample = s[23] ? 24'h000000 : {s[22:0], 1'b0};
        end else begin
            code_sample = {~s[23], s[22:0]};
        end
    endfunction : code_sample

    logic [6:0]     pin_raw;
    logic [6:0]     s1_r;
    logic [6:0]     s2_r;
    logic [6:0]     s3_r;
    logic [6:0]     pin_r;
    logic [6:0]     pin_d_r;
    afp_dev_state_t state_r;
    logic [4:0]     cnt_r;
    logic [23:0]    shift_r;
    logic [23:0]    control_r;
    logic [23:0]    cal_r;
    logic [23:0]    data_r;
    logic [7:0]     div_r;
    logic           sclk_r;
    logic           sclk_oe_r;
    logic           sdo_r;
    logic           sdo_oe_r;
    logic           result_ready_n_r;
    logic           rd_data_r;
    logic           cal_busy_r;
    logic           cal_start_r;
    logic           filt_rst_r;

    assign pin_raw = {clock_mode_i, filter_sync_n_i, link.register_select, link.read_frame_sync_n,
                      link.write_frame_sync_n, link.serial_data_io, link.sclk};

    // a pin change counts only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r    <= `AFP_DEV_PIN_IDLE;
            s2_r    <= `AFP_DEV_PIN_IDLE;
            s3_r    <= `AFP_DEV_PIN_IDLE;
            pin_r   <= `AFP_DEV_PIN_IDLE;
            pin_d_r <= `AFP_DEV_PIN_IDLE;
        end else begin
            s1_r    <= pin_raw;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            pin_r   <= (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
            pin_d_r <= pin_r;
        end
    end

    wire self_mode = pin_r[P_MODE];
    wire tfs_fall  = pin_d_r[P_TFS] & ~pin_r[P_TFS];
    wire rfs_fall  = pin_d_r[P_RFS] & ~pin_r[P_RFS];
    wire cnt_full  = (cnt_r == `AFP_CNT_FULL);
    wire [2:0] md  = control_r[`AFP_MD_HI:`AFP_MD_LO];

    // self clock stops low after the 24th cycle
    wire clk_run   = self_mode & (state_r != DEV_IDLE) & (~cnt_full | sclk_r);
    wire tick      = clk_run & (div_r == HALF_M1);
    wire ext_rise  = pin_r[P_SCLK] & ~pin_d_r[P_SCLK];
    wire ext_fall  = ~pin_r[P_SCLK] & pin_d_r[P_SCLK];
    wire rise_ev   = self_mode ? (tick & ~sclk_r) : ext_rise;
    wire fall_ev   = self_mode ? (tick & sclk_r) : ext_fall;

    wire rd_is_data = pin_r[P_SEL] & (md != `AFP_MD_COEF);
    wire rd_allowed = ~rd_is_data | ~result_ready_n_r;
    wire [23:0] rd_word = ~pin_r[P_SEL] ? control_r : (rd_is_data ? data_r : cal_r);
    wire wr_commit = (state_r == DEV_WRITE) & pin_r[P_TFS] & cnt_full;
    wire rd_done   = (state_r == DEV_READ) & rise_ev & (cnt_r == `AFP_CNT_LAST) & rd_data_r;
    wire cal_req   = (shift_r[`AFP_MD_HI:`AFP_MD_LO] == `AFP_MD_SELF_CAL)
                   | (shift_r[`AFP_MD_HI:`AFP_MD_LO] == `AFP_MD_SYS_CAL);
    wire sample_ok = sample_valid_i & ~((state_r == DEV_READ) & rd_data_r);

    always_ff @(posedge clk_i) begin
        if (rst_i || !clk_run) begin
            div_r  <= 8'h00;
            sclk_r <= 1'b0;
        end else if (tick) begin
            div_r  <= 8'h00;
            sclk_r <= ~sclk_r;
        end else begin
            div_r  <= div_r + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_oe_r <= 1'b0;
        end else begin
            sclk_oe_r <= self_mode & (state_r != DEV_IDLE);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r   <= DEV_IDLE;
            cnt_r     <= 5'h00;
            shift_r   <= 24'h000000;
            sdo_r     <= 1'b1;
            sdo_oe_r  <= 1'b0;
            rd_data_r <= 1'b0;
        end else begin
            unique case (state_r)
                DEV_IDLE: begin
                    cnt_r <= 5'h00;
                    if (tfs_fall) begin
                        state_r <= DEV_WRITE;
                    end else if (rfs_fall && rd_allowed) begin
                        state_r   <= DEV_READ;
                        shift_r   <= rd_word;
                        sdo_r     <= rd_word[23];
                        sdo_oe_r  <= 1'b1;
                        rd_data_r <= rd_is_data;
                    end
                end
                DEV_WRITE: begin
                    if (rise_ev && !cnt_full) begin
                        shift_r <= {shift_r[22:0], pin_r[P_SERIAL_DATA_IO]};
                        cnt_r   <= cnt_r + 5'h01;
                    end
                    if (pin_r[P_TFS]) begin
                        state_r <= DEV_IDLE;
                    end
                end
                DEV_READ: begin
                    if (rise_ev && !cnt_full) begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                    if (fall_ev && !cnt_full) begin
                        shift_r <= {shift_r[22:0], 1'b0};
                        sdo_r   <= shift_r[22];
                    end
                    if (pin_r[P_RFS]) begin
                        state_r  <= DEV_IDLE;
                        sdo_oe_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= DEV_IDLE;
                end
            endcase
        end
    end

    // later assignments win: a word write beats calibration end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control_r   <= `AFP_CTRL_RESET;
            cal_r       <= 24'h000000;
            data_r      <= 24'h000000;
            result_ready_n_r      <= 1'b1;
            cal_busy_r  <= 1'b0;
            cal_start_r <= 1'b0;
            filt_rst_r  <= 1'b0;
        end else begin
            cal_start_r <= 1'b0;
            filt_rst_r  <= ~pin_r[P_FSYNC];
            if (!pin_r[P_FSYNC]) begin
                result_ready_n_r <= 1'b1;
            end
            if (rd_done) begin
                result_ready_n_r <= 1'b1;
            end
            if (sample_ok) begin
                data_r <= code_sample(sample_i, control_r[`AFP_UNI_BIT]);
                result_ready_n_r <= 1'b0;
            end
            if (cal_busy_r && cal_done_i) begin
                cal_busy_r <= 1'b0;
                control_r[`AFP_MD_HI:`AFP_MD_LO] <= `AFP_MD_NORMAL;
                result_ready_n_r     <= 1'b0;
            end
            if (wr_commit) begin
                if (!pin_r[P_SEL]) begin
                    control_r   <= shift_r;
                    cal_busy_r  <= cal_req;
                    cal_start_r <= cal_req;
                end else begin
                    cal_r <= shift_r;
                end
            end
        end
    end

    assign control_o           = control_r;
    assign cal_coef_o          = cal_r;
    assign cal_start_o         = cal_start_r;
    assign current_on_o        = control_r[`AFP_IO_BIT];
    assign filter_reset_o      = filt_rst_r;
    assign link.dev_sclk_o     = sclk_r;
    assign link.dev_sclk_oe    = sclk_oe_r;
    assign link.dev_serial_data_io_o    = sdo_r;
    assign link.dev_serial_data_io_oe   = sdo_oe_r;
    assign link.result_ready_n = result_ready_n_r;
endmodule : afp_device
`default_nettype wire

// ---- afp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "afp_defines.svh"
module afp_host
    import afp_pkg::*;
#(
    parameter int SCLK_HALF = `AFP_SCLK_HALF
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    afp_link_if.host         link
);
    localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] m;
        m     = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (dat & m);
    endfunction : merge

    afp_hst_state_t st_r;
    logic [2:0]     hs1_r;
    logic [2:0]     hs2_r;
    logic [2:0]     hs3_r;
    logic [2:0]     hpin_r;
    logic [2:0]     hpin_d_r;
    logic [3:0]     ctrl_r;
    logic [23:0]    tx_r;
    logic [23:0]    rx_r;
    logic [23:0]    sh_r;
    logic [1:0]     istat_r;
    logic [1:0]     imask_r;
    logic [31:0]    dat_r;
    logic           ack_r;
    logic           irq_r;
    logic [7:0]     div_r;
    logic [4:0]     cnt_r;
    logic           hsclk_r;
    logic           sclk_oe_r;
    logic           tfs_r;
    logic           rfs_r;
    logic           sel_r;
    logic           sdo_r;
    logic           sdo_oe_r;
    logic           dir_r;
    logic           ext_r;
    logic           done_r;

    wire req     = wb_cyc_i & wb_stb_i;
    wire wr_now  = req & wb_we_i & ack_r;
    wire hit_ctl = (wb_adr_i == `AFP_REG_CTRL);
    wire hit_tx  = (wb_adr_i == `AFP_REG_TXDATA);
    wire hit_is  = (wb_adr_i == `AFP_REG_IRQ_STAT);
    wire hit_im  = (wb_adr_i == `AFP_REG_IRQ_MASK);
    wire busy    = (st_r != HST_IDLE);
    wire go      = wr_now & hit_ctl & wb_sel_i[0] & wb_dat_i[`AFP_CTRL_GO] & ~busy;
    wire rdy     = ~hpin_r[2];
    wire rdy_ev  = ~hpin_r[2] & hpin_d_r[2];
    wire [31:0] m_ctl = merge({28'h0000000, ctrl_r}, wb_dat_i, wb_sel_i);
    wire [31:0] m_tx  = merge({8'h00, tx_r}, wb_dat_i, wb_sel_i);
    wire [1:0]  clr   = (wr_now & hit_is & wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;
    wire [1:0]  ev    = {rdy_ev, done_r};

    wire [31:0] rd_mux =
        (wb_adr_i == `AFP_REG_CTRL)     ? {28'h0000000, ctrl_r[3:1], 1'b0} :
        (wb_adr_i == `AFP_REG_TXDATA)   ? {8'h00, tx_r} :
        (wb_adr_i == `AFP_REG_RXDATA)   ? {8'h00, rx_r} :
        (wb_adr_i == `AFP_REG_STATUS)   ? {30'h00000000, rdy, busy} :
        (wb_adr_i == `AFP_REG_IRQ_STAT) ? {30'h00000000, istat_r} :
        (wb_adr_i == `AFP_REG_IRQ_MASK) ? {30'h00000000, imask_r} : 32'h00000000;

    // an event in the same cycle as its clear survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            dat_r   <= 32'h00000000;
            ctrl_r  <= 4'h0;
            tx_r    <= 24'h000000;
            istat_r <= 2'h0;
            imask_r <= 2'h0;
            irq_r   <= 1'b0;
        end else begin
            ack_r   <= req & ~ack_r;
            if (req && !ack_r) begin
                dat_r <= rd_mux;
            end
            if (wr_now && hit_ctl) begin
                ctrl_r <= {m_ctl[3:1], 1'b0};
            end
            if (wr_now && hit_tx) begin
                tx_r <= m_tx[23:0];
            end
            if (wr_now && hit_im && wb_sel_i[0]) begin
                imask_r <= wb_dat_i[1:0];
            end
            istat_r <= (istat_r & ~clr) | ev;
            irq_r   <= |(istat_r & imask_r);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs1_r    <= `AFP_HST_PIN_IDLE;
            hs2_r    <= `AFP_HST_PIN_IDLE;
            hs3_r    <= `AFP_HST_PIN_IDLE;
            hpin_r   <= `AFP_HST_PIN_IDLE;
            hpin_d_r <= `AFP_HST_PIN_IDLE;
        end else begin
            hs1_r    <= {link.result_ready_n, link.serial_data_io, link.sclk};
            hs2_r    <= hs1_r;
            hs3_r    <= hs2_r;
            hpin_r   <= (hs2_r & hs3_r) | (hpin_r & (hs2_r | hs3_r));
            hpin_d_r <= hpin_r;
        end
    end

    wire ext_tick = ext_r & (st_r == HST_SHIFT) & (div_r == HALF_M1);
    wire h_rise   = ext_r ? (ext_tick & ~hsclk_r) : (hpin_r[0] & ~hpin_d_r[0]);
    wire h_fall   = ext_r ? (ext_tick & hsclk_r) : (~hpin_r[0] & hpin_d_r[0]);
    // own clock: sample before the device reacts; its clock: half a period after
    wire take     = dir_r & (ext_r ? h_fall : h_rise);
    wire last     = h_fall & (cnt_r == `AFP_CNT_FULL);
    // device clock: move after its rise, its sampler sees our data four cycles late
    wire move     = ~dir_r & (ext_r ? h_fall : h_rise);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r      <= HST_IDLE;
            div_r     <= 8'h00;
            cnt_r     <= 5'h00;
            hsclk_r   <= 1'b0;
            sclk_oe_r <= 1'b0;
            tfs_r     <= 1'b1;
            rfs_r     <= 1'b1;
            sel_r     <= 1'b0;
            sdo_r     <= 1'b1;
            sdo_oe_r  <= 1'b0;
            dir_r     <= 1'b0;
            ext_r     <= 1'b0;
            sh_r      <= 24'h000000;
            rx_r      <= 24'h000000;
            done_r    <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (st_r)
                HST_IDLE: begin
                    if (go) begin
                        dir_r <= wb_dat_i[`AFP_CTRL_READ];
                        sel_r <= wb_dat_i[`AFP_CTRL_SEL];
                        ext_r <= wb_dat_i[`AFP_CTRL_EXT];
                        st_r  <= (wb_dat_i[`AFP_CTRL_READ] & wb_dat_i[`AFP_CTRL_SEL]) ? HST_WAIT_RDY : HST_SETUP;
                    end
                end
                HST_WAIT_RDY: begin
                    if (rdy) begin
                        st_r <= HST_SETUP;
                    end
                end
                HST_SETUP: begin
                    div_r     <= 8'h00;
                    cnt_r     <= 5'h00;
                    hsclk_r   <= 1'b0;
                    sclk_oe_r <= ext_r;
                    sh_r      <= tx_r;
                    tfs_r     <= dir_r;
                    rfs_r     <= ~dir_r;
                    sdo_r     <= tx_r[23];
                    sdo_oe_r  <= ~dir_r;
                    st_r      <= HST_SHIFT;
                end
                HST_SHIFT: begin
                    div_r <= ext_tick ? 8'h00 : div_r + 8'h01;
                    if (ext_tick) begin
                        hsclk_r <= ~hsclk_r;
                    end
                    if (h_rise && cnt_r != `AFP_CNT_FULL) begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                    if (take) begin
                        sh_r <= {sh_r[22:0], hpin_r[1]};
                    end
                    if (move) begin
                        sh_r  <= {sh_r[22:0], 1'b0};
                        sdo_r <= sh_r[22];
                    end
                    if (last) begin
                        div_r <= 8'h00;
                        st_r  <= HST_END;
                    end
                end
                HST_END: begin
                    tfs_r     <= 1'b1;
                    rfs_r     <= 1'b1;
                    sdo_oe_r  <= 1'b0;
                    sclk_oe_r <= 1'b0;
                    div_r     <= div_r + 8'h01;
                    if (div_r == HALF_M1) begin
                        rx_r   <= sh_r;
                        done_r <= 1'b1;
                        st_r   <= HST_IDLE;
                    end
                end
                default: begin
                    st_r <= HST_IDLE;
                end
            endcase
        end
    end

    assign wb_dat_o                = dat_r;
    assign wb_ack_o                = ack_r;
    assign irq_o                   = irq_r;
    assign link.host_sclk_o        = hsclk_r;
    assign link.host_sclk_oe       = sclk_oe_r;
    assign link.host_serial_data_io_o       = sdo_r;
    assign link.host_serial_data_io_oe      = sdo_oe_r;
    assign link.write_frame_sync_n = tfs_r;
    assign link.read_frame_sync_n  = rfs_r;
    assign link.register_select    = sel_r;
endmodule : afp_host
`default_nettype wire

// ---- afp_link_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module afp_link_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic serial_data_io,
    input wire logic dev_sclk_o,
    input wire logic dev_sclk_oe,
    input wire logic dev_serial_data_io_o,
    input wire logic dev_serial_data_io_oe,
    input wire logic write_frame_sync_n,
    input wire logic read_frame_sync_n,
    input wire logic result_ready_n,
    input wire logic register_select
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] rise_cnt_r;
    // saturate so a runaway clock cannot wrap back under the limit
    always_ff @(posedge clk_i) begin
        if (rst_i || (write_frame_sync_n && read_frame_sync_n))
            rise_cnt_r <= 5'h00;
        else if ($rose(sclk) && rise_cnt_r != 5'h1F)
            rise_cnt_r <= rise_cnt_r + 5'h01;
    end
    rd_drive_a: assert property ($rose(dev_serial_data_io_oe) |-> !read_frame_sync_n)
        else $error("device drives data outside a read frame");
    wr_quiet_a: assert property (dev_serial_data_io_oe |-> write_frame_sync_n)
        else $error("device drives data during a write frame");
    self_clk_a: assert property ($rose(dev_sclk_oe) |-> !(write_frame_sync_n && read_frame_sync_n))
        else $error("device clock starts without a frame");
    clk_half_a: assert property ($rose(dev_sclk_o) && dev_sclk_oe |=> dev_sclk_o [*7])
        else $error("device clock high phase too short");
    rdy_gate_a: assert property ($rose(dev_serial_data_io_oe) && register_select |-> !result_ready_n)
        else $error("data read driven while ready high");
    rdy_rise_a: assert property ($rose(result_ready_n) |-> !read_frame_sync_n)
        else $error("ready released outside a read");
    rdy_fall_a: assert property ($fell(result_ready_n) |-> read_frame_sync_n || !register_select)
        else $error("ready fell during a data read");
    wr_hold_a: assert property ($rose(sclk) && !write_frame_sync_n |=> $stable(serial_data_io))
        else $error("written bit moved at clock rise");
    dev_hold_a: assert property ($rose(sclk) && dev_serial_data_io_oe |=> $stable(dev_serial_data_io_o))
        else $error("read bit moved at clock rise");
    bit_count_a: assert property (rise_cnt_r <= 5'h18)
        else $error("more than 24 clocks in a frame");
endmodule : afp_link_chk
`default_nettype wire

// ---- tb_adc_framed_serial_host_port.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "afp_defines.svh"
module tb_adc_framed_serial_host_port;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, mode = 1'b0;
    logic        fsync_n = 1'b1, svalid = 1'b0, cdone = 1'b0, seen_cal = 1'b0, e;
    logic        ack, irq, cur_on, frst, cstart;
    logic [3:0]  sel = 4'hF;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [23:0] samp = 24'h0, ctl, coef, cw, ex;
    int          fail_count = 0, total_checks = 0, cyc_cnt = 0;
    afp_link_if link ();
    afp_host afp_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .link(link));
    afp_device afp_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .clock_mode_i(mode),
        .filter_sync_n_i(fsync_n), .sample_i(samp), .sample_valid_i(svalid), .cal_done_i(cdone),
        .control_o(ctl), .cal_coef_o(coef), .cal_start_o(cstart), .current_on_o(cur_on), .filter_reset_o(frst));
    afp_link_chk afp_link_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk),
        .serial_data_io(link.serial_data_io), .dev_sclk_o(link.dev_sclk_o), .dev_sclk_oe(link.dev_sclk_oe),
        .dev_serial_data_io_o(link.dev_serial_data_io_o), .dev_serial_data_io_oe(link.dev_serial_data_io_oe),
        .write_frame_sync_n(link.write_frame_sync_n), .read_frame_sync_n(link.read_frame_sync_n),
        .result_ready_n(link.result_ready_n), .register_select(link.register_select));
    initial forever #12.5 clk_i = ~clk_i;
    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // a hung handshake ends here instead of running forever
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cstart === 1'b1) seen_cal <= 1'b1;
        if (cyc_cnt == 40000) begin
            fail_count++;
            finish_test();
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task xfer(input logic [3:0] c, input logic [23:0] d);
        wb(1'b1, `AFP_REG_TXDATA, {8'h00, d});
        wb(1'b1, `AFP_REG_CTRL, {28'h0, c});
        do wb(1'b0, `AFP_REG_IRQ_STAT, 32'h0); while (q[`AFP_IRQ_DONE] !== 1'b1);
        wb(1'b1, `AFP_REG_IRQ_STAT, 32'h1);
    endtask : xfer
    task pulse(input logic c);
        @(posedge clk_i);
        if (c) cdone <= 1'b1;
        else svalid <= 1'b1;
        @(posedge clk_i);
        cdone  <= 1'b0;
        svalid <= 1'b0;
        // the ready interrupt lags the pin by its synchroniser
        repeat (8) @(posedge clk_i);
    endtask : pulse
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b1, `AFP_REG_IRQ_MASK, 32'h2);
        for (int m = 0; m < 2; m++) begin
            e = ~m[0];
            cw = m[0] ? 24'h004000 : 24'h005000;
            ex = m[0] ? 24'h923456 : 24'h2468AC;
            mode <= m[0];
            repeat (8) @(posedge clk_i);
            xfer({e, 3'b001}, cw);
            chk("control", ctl, cw);
            chk("current", cur_on, 1'b1);
            xfer({e, 3'b011}, 24'h0);
            wb(1'b0, `AFP_REG_RXDATA, 32'h0);
            chk("control read", q, cw);
            samp <= 24'h123456;
            pulse(1'b0);
            chk("ready low", link.result_ready_n, 1'b0);
            chk("irq set", irq, 1'b1);
            xfer({e, 3'b111}, 24'h0);
            wb(1'b0, `AFP_REG_RXDATA, 32'h0);
            chk("result", q, ex);
            chk("ready high", link.result_ready_n, 1'b1);
            wb(1'b1, `AFP_REG_IRQ_STAT, 32'h2);
            xfer({e, 3'b101}, 24'h5A5A00 + m[0]);
            chk("coefficient", coef, 24'h5A5A00 + m[0]);
            chk("irq clear", irq, 1'b0);
            $display("mode %0d test done", m);
        end
        fsync_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("filter reset", frst, 1'b1);
        fsync_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        xfer(4'b0001, 24'h200000);
        chk("cal start", seen_cal, 1'b1);
        pulse(1'b1);
        chk("cal mode", ctl[23:21], 3'h0);
        chk("cal ready", link.result_ready_n, 1'b0);
        xfer(4'b0001, 24'hE00000);
        xfer(4'b0111, 24'h0);
        wb(1'b0, `AFP_REG_RXDATA, 32'h0);
        chk("coef read", q, 32'h005A5A01);
        $display("calibration and filter test done");
        finish_test();
    end
endmodule : tb_adc_framed_serial_host_port
`default_nettype wire
